// ===== rtl/pmw_beat_fifo.sv
// two-entry beat buffer between local data and the pci data lines
`timescale 1ns/1ps
`include "pmw_cfg.svh"

module pmw_beat_fifo
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // filling side
    input  wire logic              i_in_valid,
    input  wire pmw_pkg::pmw_beat_t i_in_beat,
    output logic                   o_in_ready,
    // draining side
    output logic                   o_out_valid,
    output pmw_pkg::pmw_beat_t     o_out_beat,
    input  wire logic              i_out_ready
);

    pmw_pkg::pmw_beat_t mem [2];
    logic               wr_ptr;
    logic               rd_ptr;
    logic [1:0]         count;
    logic               push;
    logic               pop;

    assign o_in_ready  = (count != `PMW_FIFO_FULL);
    assign o_out_valid = (count != `PMW_FIFO_EMPTY);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    // head word comes straight from the storage flops
    assign o_out_beat  = mem[rd_ptr];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= i_in_beat;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= `PMW_FIFO_EMPTY;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
            begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop)
            begin
                count <= count + `PMW_FIFO_ONE;
            end
            else if (pop && !push)
            begin
                count <= count - `PMW_FIFO_ONE;
            end
        end
    end

endmodule

// ===== rtl/pmw_cfg.svh
// constants for the pci master single write sequencer
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH

// local master state codes
`define PMW_ST_IDLE       4'h0
`define PMW_ST_ADDR_LOAD  4'h1
`define PMW_ST_BUS_TRANS  4'h2
`define PMW_ST_BUS_TERM   4'h3

// termination codes
`define PMW_TERM_NONE     3'h0
`define PMW_TERM_NORMAL   3'h1

// field layout and fixed values
`define PMW_ADDR_LO       31:0
`define PMW_CMD_LO        3:0
`define PMW_ADDR_HI_PAD   32'h0000_0000
`define PMW_CBE_HI_PAD    4'hf
`define PMW_CNT_ZERO      13'h0000
`define PMW_CNT_STEP      13'h0001
`define PMW_FIFO_EMPTY    2'h0
`define PMW_FIFO_FULL     2'h2
`define PMW_FIFO_ONE      2'h1

`endif

// ===== rtl/pmw_master.sv
// pci 64-bit master sequencer for a single memory write from a 64-bit local bus
//
// Functional notes
// - local request seen: assert pci bus request
// - grant on idle bus asserts local grant
// - request plus grant: address loading, fields latched
// - grant after loading: frame, req64, address, command
// - address phase shows bus transaction state
// - address phase loads burst counter with length
// - both dword strobes taken while data accepted
// - frame and no local request drops bus request
// - data and byte enables follow the strobes
// - first data phase waits with irdy deasserted
// - ack64 with trdy no later than devsel asserts wide transfer indicator
// - local grant follows pci grant when dropped
// - ready: irdy asserted, frame dropped, single phase
// - after completion release lines, counter down by one unless already zero
// - completion gives bus termination, normal termination
// - one clock after turnaround release irdy, parity
`timescale 1ns/1ps
`include "pmw_cfg.svh"

module pmw_master
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // local master request side
    input  wire logic        i_local_req64_l,
    input  wire logic [63:0] i_local_ad_in,
    input  wire logic [7:0]  i_local_cmd_byte_en_in,
    input  wire logic [12:0] i_local_burst_len,
    input  wire logic        i_local_ready_l,
    // local master answer side
    output logic             o_local_grant_l,
    output logic [3:0]       o_local_master_state,
    output logic [2:0]       o_local_term_code,
    output logic             o_low_dword_strobe_l,
    output logic             o_high_dword_strobe_l,
    output logic             o_wide_transfer_ind_l,
    output logic [12:0]      o_local_burst_counter,
    // pci arbitration
    input  wire logic        i_gnt_l,
    output logic             o_req_l,
    // pci frame, irdy and req64
    input  wire logic        i_frame_l,
    output logic             o_frame_l,
    output logic             o_frame_oe,
    input  wire logic        i_irdy_l,
    output logic             o_irdy_l,
    output logic             o_irdy_oe,
    output logic             o_req64_l,
    output logic             o_req64_oe,
    // pci target answers
    input  wire logic        i_trdy_l,
    input  wire logic        i_devsel_l,
    input  wire logic        i_ack64_l,
    // pci address/data and command/byte enables
    input  wire logic [63:0] i_ad,
    output logic [63:0]      o_ad,
    output logic             o_ad_oe,
    input  wire logic [7:0]  i_cbe,
    output logic [7:0]       o_cbe,
    output logic             o_cbe_oe,
    // pci parity
    output logic             o_par,
    output logic             o_par_oe,
    output logic             o_par64,
    output logic             o_par64_oe
);

    pmw_pkg::pmw_state_t state;
    pmw_pkg::pmw_state_t next_state;

    logic [63:0]         addr_word;
    logic [7:0]          cmd_word;
    logic [12:0]         burst_len_q;
    logic                data_phase;
    logic                beat_taken;
    logic                next_strobe;
    logic                bus_idle;

    pmw_pkg::pmw_beat_t  in_beat;
    pmw_pkg::pmw_beat_t  head_beat;
    logic                buf_in_ready;
    logic                buf_out_valid;
    logic                buf_pop;

    // read back only so the bidirectional lines have a consumer on this side
    logic                unused_in;

    assign unused_in = ^{i_ad, i_cbe};

    // the block owns the bus only after frame and irdy are both idle
    assign bus_idle  = i_frame_l && i_irdy_l;

    // sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            pmw_pkg::PMW_IDLE:
            begin
                if (!i_local_req64_l)
                begin
                    next_state = pmw_pkg::PMW_REQ;
                end
            end
            pmw_pkg::PMW_REQ:
            begin
                if (!i_gnt_l && bus_idle)
                begin
                    next_state = pmw_pkg::PMW_GRANTED;
                end
            end
            pmw_pkg::PMW_GRANTED:
            begin
                if (i_gnt_l)
                begin
                    next_state = pmw_pkg::PMW_REQ;
                end
                else if (!i_local_req64_l && !o_local_grant_l)
                begin
                    next_state = pmw_pkg::PMW_LOAD;
                end
            end
            pmw_pkg::PMW_LOAD:
            begin
                // grant lost here means waiting for it again before the address phase
                if (!i_gnt_l)
                begin
                    next_state = pmw_pkg::PMW_ADDR;
                end
            end
            pmw_pkg::PMW_ADDR:
            begin
                next_state = pmw_pkg::PMW_DPH1;
            end
            pmw_pkg::PMW_DPH1:
            begin
                // irdy held off until devsel shows and the width is judged
                if (!i_devsel_l)
                begin
                    next_state = pmw_pkg::PMW_JUDGE;
                end
            end
            pmw_pkg::PMW_JUDGE:
            begin
                if (!i_local_ready_l && buf_out_valid)
                begin
                    next_state = pmw_pkg::PMW_DATA;
                end
            end
            pmw_pkg::PMW_DATA:
            begin
                if (!i_trdy_l)
                begin
                    next_state = pmw_pkg::PMW_TURN;
                end
            end
            pmw_pkg::PMW_TURN:
            begin
                next_state = pmw_pkg::PMW_IDLE;
            end
            default:
            begin
                next_state = pmw_pkg::PMW_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= pmw_pkg::PMW_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // pci bus request
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_req_l <= 1'b1;
        end
        else if (state == pmw_pkg::PMW_IDLE && !i_local_req64_l)
        begin
            o_req_l <= 1'b0;
        end
        else if (!o_frame_l && o_frame_oe && i_local_req64_l)
        begin
            o_req_l <= 1'b1;
        end
    end

    // local grant
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_local_grant_l <= 1'b1;
        end
        else if (i_gnt_l)
        begin
            o_local_grant_l <= 1'b1;
        end
        else if (state == pmw_pkg::PMW_REQ && bus_idle)
        begin
            o_local_grant_l <= 1'b0;
        end
    end

    // address, command and length are caught on entry to address loading
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            addr_word   <= '0;
            cmd_word    <= '0;
            burst_len_q <= `PMW_CNT_ZERO;
        end
        else if (next_state == pmw_pkg::PMW_LOAD && state != pmw_pkg::PMW_LOAD)
        begin
            addr_word   <= {`PMW_ADDR_HI_PAD, i_local_ad_in[`PMW_ADDR_LO]};
            cmd_word    <= {`PMW_CBE_HI_PAD, i_local_cmd_byte_en_in[`PMW_CMD_LO]};
            burst_len_q <= i_local_burst_len;
        end
    end

    // local state and termination codes
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_local_master_state <= `PMW_ST_IDLE;
            o_local_term_code    <= `PMW_TERM_NONE;
        end
        else if (next_state == pmw_pkg::PMW_LOAD && state != pmw_pkg::PMW_LOAD)
        begin
            o_local_master_state <= `PMW_ST_ADDR_LOAD;
            o_local_term_code    <= `PMW_TERM_NONE;
        end
        else if (next_state == pmw_pkg::PMW_ADDR)
        begin
            o_local_master_state <= `PMW_ST_BUS_TRANS;
        end
        else if (next_state == pmw_pkg::PMW_TURN)
        begin
            o_local_master_state <= `PMW_ST_BUS_TERM;
            o_local_term_code    <= `PMW_TERM_NORMAL;
        end
    end

    // burst counter
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_local_burst_counter <= `PMW_CNT_ZERO;
        end
        else if (next_state == pmw_pkg::PMW_ADDR)
        begin
            o_local_burst_counter <= burst_len_q;
        end
        else if (next_state == pmw_pkg::PMW_TURN && o_local_burst_counter != `PMW_CNT_ZERO)
        begin
            o_local_burst_counter <= o_local_burst_counter - `PMW_CNT_STEP;
        end
    end

    // dword strobes: only one beat per transaction, so a full buffer just delays it
    always_comb
    begin
        next_strobe = 1'b0;
        if ((next_state == pmw_pkg::PMW_ADDR || next_state == pmw_pkg::PMW_DPH1 ||
             next_state == pmw_pkg::PMW_JUDGE) &&
            !beat_taken && o_low_dword_strobe_l && !i_local_ready_l && buf_in_ready)
        begin
            next_strobe = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_low_dword_strobe_l  <= 1'b1;
            o_high_dword_strobe_l <= 1'b1;
        end
        else
        begin
            o_low_dword_strobe_l  <= ~next_strobe;
            o_high_dword_strobe_l <= ~next_strobe;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            beat_taken <= 1'b0;
        end
        else if (next_state == pmw_pkg::PMW_IDLE)
        begin
            beat_taken <= 1'b0;
        end
        else if (!o_low_dword_strobe_l)
        begin
            beat_taken <= 1'b1;
        end
    end

    // beat is sampled in the strobe cycle and drained by the completing data phase
    assign in_beat      = '{data: i_local_ad_in,
                            be:   i_local_cmd_byte_en_in};
    assign buf_pop      = (state == pmw_pkg::PMW_DATA) && !i_trdy_l;

    pmw_beat_fifo u_beat_fifo
    (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (!o_low_dword_strobe_l),
        .i_in_beat   (in_beat),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (buf_out_valid),
        .o_out_beat  (head_beat),
        .i_out_ready (buf_pop)
    );

    // wide transfer indicator
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_wide_transfer_ind_l <= 1'b1;
        end
        else if (next_state == pmw_pkg::PMW_IDLE)
        begin
            o_wide_transfer_ind_l <= 1'b1;
        end
        else if (state == pmw_pkg::PMW_DPH1 && !i_ack64_l && !i_trdy_l)
        begin
            o_wide_transfer_ind_l <= 1'b0;
        end
    end

    // frame, req64, irdy and their enables
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_frame_l  <= 1'b1;
            o_frame_oe <= 1'b0;
            o_req64_l  <= 1'b1;
            o_req64_oe <= 1'b0;
            o_irdy_l   <= 1'b1;
            o_irdy_oe  <= 1'b0;
        end
        else
        begin
            case (next_state)
                pmw_pkg::PMW_ADDR, pmw_pkg::PMW_DPH1, pmw_pkg::PMW_JUDGE:
                begin
                    o_frame_l  <= 1'b0;
                    o_frame_oe <= 1'b1;
                    o_req64_l  <= 1'b0;
                    o_req64_oe <= 1'b1;
                    o_irdy_l   <= 1'b1;
                    o_irdy_oe  <= 1'b1;
                end
                pmw_pkg::PMW_DATA:
                begin
                    o_frame_l  <= 1'b1;
                    o_frame_oe <= 1'b1;
                    o_req64_l  <= 1'b1;
                    o_req64_oe <= 1'b1;
                    o_irdy_l   <= 1'b0;
                    o_irdy_oe  <= 1'b1;
                end
                pmw_pkg::PMW_TURN:
                begin
                    o_frame_l  <= 1'b1;
                    o_frame_oe <= 1'b0;
                    o_req64_l  <= 1'b1;
                    o_req64_oe <= 1'b0;
                    o_irdy_l   <= 1'b1;
                    o_irdy_oe  <= 1'b1;
                end
                default:
                begin
                    o_frame_l  <= 1'b1;
                    o_frame_oe <= 1'b0;
                    o_req64_l  <= 1'b1;
                    o_req64_oe <= 1'b0;
                    o_irdy_l   <= 1'b1;
                    o_irdy_oe  <= 1'b0;
                end
            endcase
        end
    end

    // ad/cbe enables; the data itself is muxed from address latch or buffer head
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_ad_oe    <= 1'b0;
            o_cbe_oe   <= 1'b0;
            data_phase <= 1'b0;
        end
        else
        begin
            o_ad_oe    <= (next_state == pmw_pkg::PMW_ADDR) || (next_state == pmw_pkg::PMW_DPH1) ||
                          (next_state == pmw_pkg::PMW_JUDGE) || (next_state == pmw_pkg::PMW_DATA);
            o_cbe_oe   <= (next_state == pmw_pkg::PMW_ADDR) || (next_state == pmw_pkg::PMW_DPH1) ||
                          (next_state == pmw_pkg::PMW_JUDGE) || (next_state == pmw_pkg::PMW_DATA);
            data_phase <= (next_state == pmw_pkg::PMW_DPH1) || (next_state == pmw_pkg::PMW_JUDGE) ||
                          (next_state == pmw_pkg::PMW_DATA);
        end
    end

    assign o_ad  = data_phase ? head_beat.data : addr_word;
    assign o_cbe = data_phase ? head_beat.be : cmd_word;

    pmw_parity u_parity
    (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_ad       (o_ad),
        .i_cbe      (o_cbe),
        .i_ad_oe    (o_ad_oe),
        .i_wide_oe  (o_ad_oe && data_phase),
        .o_par      (o_par),
        .o_par_oe   (o_par_oe),
        .o_par64    (o_par64),
        .o_par64_oe (o_par64_oe)
    );

endmodule

// ===== rtl/pmw_parity.sv
// even parity for ad/cbe, one clock behind the lines it covers
`timescale 1ns/1ps

module pmw_parity
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // lines being driven this cycle
    input  wire logic [63:0] i_ad,
    input  wire logic [7:0]  i_cbe,
    input  wire logic        i_ad_oe,
    input  wire logic        i_wide_oe,
    // parity pins
    output logic             o_par,
    output logic             o_par_oe,
    output logic             o_par64,
    output logic             o_par64_oe
);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_par      <= 1'b0;
            o_par64    <= 1'b0;
            o_par_oe   <= 1'b0;
            o_par64_oe <= 1'b0;
        end
        else
        begin
            o_par      <= ^{i_ad[31:0], i_cbe[3:0]};
            o_par64    <= ^{i_ad[63:32], i_cbe[7:4]};
            // parity lets go one clock after the lines it covers
            o_par_oe   <= i_ad_oe;
            o_par64_oe <= i_wide_oe;
        end
    end

endmodule

// ===== rtl/pmw_pkg.sv
// shared types for the pci master single write sequencer
package pmw_pkg;

    // one 64-bit write beat with its byte enables
    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  be;
    } pmw_beat_t;

    typedef enum logic [3:0] {
        PMW_IDLE,
        PMW_REQ,
        PMW_GRANTED,
        PMW_LOAD,
        PMW_ADDR,
        PMW_DPH1,
        PMW_JUDGE,
        PMW_DATA,
        PMW_TURN
    } pmw_state_t;

endpackage

// ===== tb/pmw_master_assertions.sv
// concurrent checks on the pci master sequencer ports
`timescale 1ns/1ps

module pmw_master_checker
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // watched inputs
    input wire logic        i_local_req64_l,
    input wire logic        i_local_ready_l,
    input wire logic        i_gnt_l,
    input wire logic        i_frame_l,
    input wire logic        i_irdy_l,
    input wire logic        i_trdy_l,
    input wire logic        i_ack64_l,
    // watched outputs
    input wire logic        o_req_l,
    input wire logic        o_local_grant_l,
    input wire logic [3:0]  o_local_master_state,
    input wire logic [2:0]  o_local_term_code,
    input wire logic        o_low_dword_strobe_l,
    input wire logic        o_high_dword_strobe_l,
    input wire logic        o_wide_transfer_ind_l,
    input wire logic        o_frame_l,
    input wire logic        o_frame_oe,
    input wire logic        o_irdy_l,
    input wire logic        o_irdy_oe,
    input wire logic        o_req64_l,
    input wire logic        o_req64_oe,
    input wire logic        o_ad_oe,
    input wire logic        o_par_oe,
    input wire logic        o_par64_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    bus_request_a: assert property (o_local_master_state == 4'h0 && !i_local_req64_l && o_req_l |=> !o_req_l)
        else $error("bus request not raised");
    local_grant_a: assert property (!i_gnt_l && i_frame_l && i_irdy_l && !o_req_l && o_local_grant_l
        && o_local_master_state != 4'h1 |=> !o_local_grant_l)
        else $error("local grant not given");
    addr_load_a: assert property ($fell(o_local_grant_l) && !i_local_req64_l |=> o_local_master_state == 4'h1)
        else $error("address loading not shown");
    addr_phase_a: assert property (o_local_master_state == 4'h1 && !i_gnt_l |=> !o_frame_l && o_frame_oe
        && !o_req64_l && o_req64_oe && o_local_master_state == 4'h2)
        else $error("address phase wrong");
    dword_strobe_a: assert property ($fell(o_low_dword_strobe_l) |-> !o_high_dword_strobe_l
        && !$past(i_local_ready_l) ##1 o_low_dword_strobe_l && o_high_dword_strobe_l)
        else $error("strobe pair wrong");
    req_release_a: assert property (!o_frame_l && o_frame_oe && i_local_req64_l && !o_req_l |=> o_req_l)
        else $error("bus request not dropped");
    first_wait_a: assert property ($rose(o_frame_oe) |=> !o_frame_l && o_irdy_l && o_irdy_oe)
        else $error("first data phase not held");
    wide_ind_a: assert property (!i_ack64_l && !i_trdy_l && !o_frame_l && o_frame_oe
        |=> !o_wide_transfer_ind_l)
        else $error("wide indicator missing");
    grant_follow_a: assert property (i_gnt_l && !o_local_grant_l |=> o_local_grant_l)
        else $error("local grant kept");
    phase_end_a: assert property (!o_irdy_l && o_irdy_oe && !i_trdy_l |=> o_irdy_l && o_irdy_oe && !o_frame_oe
        && !o_ad_oe && !o_req64_oe && o_local_master_state == 4'h3 && o_local_term_code == 3'h1
        ##1 !o_irdy_oe && !o_par_oe && !o_par64_oe)
        else $error("termination sequence wrong");
endmodule

bind pmw_master pmw_master_checker pmw_master_checker_inst
(
    .i_clk(i_clk), .i_rst(i_rst), .i_local_req64_l(i_local_req64_l), .i_local_ready_l(i_local_ready_l),
    .i_gnt_l(i_gnt_l), .i_frame_l(i_frame_l), .i_irdy_l(i_irdy_l), .i_trdy_l(i_trdy_l), .i_ack64_l(i_ack64_l),
    .o_req_l(o_req_l), .o_local_grant_l(o_local_grant_l), .o_local_master_state(o_local_master_state),
    .o_local_term_code(o_local_term_code), .o_low_dword_strobe_l(o_low_dword_strobe_l),
    .o_high_dword_strobe_l(o_high_dword_strobe_l), .o_wide_transfer_ind_l(o_wide_transfer_ind_l),
    .o_frame_l(o_frame_l), .o_frame_oe(o_frame_oe), .o_irdy_l(o_irdy_l), .o_irdy_oe(o_irdy_oe),
    .o_req64_l(o_req64_l), .o_req64_oe(o_req64_oe), .o_ad_oe(o_ad_oe), .o_par_oe(o_par_oe),
    .o_par64_oe(o_par64_oe)
);

// ===== tb/pmw_master_test.sv
// self-checking bench for single 64-bit master writes
`timescale 1ns/1ps

module pmw_master_test;
    logic        i_clk, i_rst, req_l, rdy_l, frame_w, irdy_w, gnt_l, trdy_l, devsel_l, ack64_l;
    logic        grant_l, lo_stb_l, hi_stb_l, wide_l, req_o_l, frame_o, frame_oe, irdy_o, irdy_oe;
    logic        req64_l, req64_oe, ad_oe, cbe_oe, par, par_oe, par64, par64_oe, frame_seen;
    logic [63:0] ad_in, ad_o, ad_seen;
    logic [7:0]  cbe_in, cbe_o, cbe_seen;
    logic [12:0] len, cnt;
    logic [3:0]  state, gnt_dly;
    logic [2:0]  term;
    int          error_cnt, n_compared, stb_seen, wide_seen;

    // pull-ups on the control wires; released ad/cbe read back as the complement of o_ad/o_cbe
    assign frame_w = frame_oe ? frame_o : 1'b1;
    assign irdy_w  = irdy_oe ? irdy_o : 1'b1;

    pmw_master pmw_master_inst
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_local_req64_l(req_l), .i_local_ad_in(ad_in),
        .i_local_cmd_byte_en_in(cbe_in), .i_local_burst_len(len), .i_local_ready_l(rdy_l),
        .o_local_grant_l(grant_l), .o_local_master_state(state), .o_local_term_code(term),
        .o_low_dword_strobe_l(lo_stb_l), .o_high_dword_strobe_l(hi_stb_l), .o_wide_transfer_ind_l(wide_l),
        .o_local_burst_counter(cnt), .i_gnt_l(gnt_l), .o_req_l(req_o_l), .i_frame_l(frame_w),
        .o_frame_l(frame_o), .o_frame_oe(frame_oe), .i_irdy_l(irdy_w), .o_irdy_l(irdy_o),
        .o_irdy_oe(irdy_oe), .o_req64_l(req64_l), .o_req64_oe(req64_oe), .i_trdy_l(trdy_l),
        .i_devsel_l(devsel_l), .i_ack64_l(ack64_l), .i_ad(ad_oe ? ad_o : ~ad_o), .o_ad(ad_o),
        .o_ad_oe(ad_oe), .i_cbe(cbe_oe ? cbe_o : ~cbe_o), .o_cbe(cbe_o), .o_cbe_oe(cbe_oe),
        .o_par(par), .o_par_oe(par_oe), .o_par64(par64), .o_par64_oe(par64_oe)
    );

    pmw_pci_model pmw_pci_model_inst
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_req_l(req_o_l), .i_frame_l(frame_w), .i_irdy_l(irdy_w),
        .i_gnt_delay(gnt_dly), .o_gnt_l(gnt_l), .o_trdy_l(trdy_l), .o_devsel_l(devsel_l), .o_ack64_l(ack64_l)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("counts: %0d mismatches in %0d compares", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_state(input logic [3:0] s);
        for (int i = 0; i < 60 && state !== s; i++)
            @(negedge i_clk);
        if (state !== s)
        begin
            error_cnt++;
            $display("unexpected at %0t: state %h never reached", $time, s);
            stop_test();
        end
    endtask

    // the wire-side view of each transfer, sampled where it has settled
    always @(negedge i_clk)
    begin
        if (!lo_stb_l && !hi_stb_l)
            stb_seen++;
        if (!wide_l)
            wide_seen++;
        if (irdy_oe && !irdy_o)
        begin
            ad_seen    = ad_o;
            cbe_seen   = cbe_o;
            frame_seen = frame_w;
        end
    end

    task automatic run_write(input logic [31:0] addr, input logic [3:0] cmd, input logic [12:0] l,
                             input logic [63:0] qw, input logic [7:0] be, input logic late);
        @(negedge i_clk);
        req_l     = 1'b0;
        ad_in     = {32'h0000_0000, addr};
        cbe_in    = {4'h0, cmd};
        len       = l;
        stb_seen  = 0;
        wide_seen = 0;
        wait_state(4'h1);
        req_l  = 1'b1;
        ad_in  = qw;
        cbe_in = be;
        rdy_l  = late;
        @(negedge i_clk);
        check({frame_o, frame_oe, req64_l, req64_oe}, 4'h5);
        check({cbe_o[3:0], ad_o[31:0]}, {cmd, addr});
        check(state, 4'h2);
        check(cnt, l);
        rdy_l = 1'b0;
        wait_state(4'h3);
        rdy_l = 1'b1;
        check(term, 3'h1);
        check(cnt, l - 13'h0001);
        check({irdy_o, irdy_oe, frame_oe, ad_oe, cbe_oe}, 5'h18);
        check({cbe_seen, ad_seen}, {be, qw});
        check({par, par64}, {^{qw[31:0], be[3:0]}, ^{qw[63:32], be[7:4]}});
        check(frame_seen, 1'b1);
        check(stb_seen, 1);
        check(wide_seen > 0, 1'b1);
        @(negedge i_clk);
        check({irdy_oe, par_oe, par64_oe}, 3'h0);
        repeat (2) @(negedge i_clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        $display("unexpected at %0t: run timed out", $time);
        stop_test();
    end

    initial
    begin
        error_cnt  = 0;
        n_compared = 0;
        i_rst      = 1'b1;
        req_l      = 1'b1;
        rdy_l      = 1'b1;
        ad_in      = 64'h0000_0000_0000_0000;
        cbe_in     = 8'h00;
        len        = 13'h0000;
        gnt_dly    = 4'h0;
        repeat (16) @(negedge i_clk);
        check({grant_l, req_o_l, lo_stb_l, hi_stb_l, wide_l, frame_oe, irdy_oe, ad_oe}, 8'hf8);
        check({state, term, cnt}, 20'h0_0000);
        i_rst = 1'b0;
        run_write(32'h1000_0040, 4'h7, 13'h0001, 64'h1122_3344_5566_7788, 8'h00, 1'b0);
        gnt_dly = 4'h3;
        run_write(32'ha5a5_0008, 4'h7, 13'h0005, 64'hdead_beef_0123_4567, 8'hf0, 1'b1);
        gnt_dly = 4'h0;
        run_write(32'hffff_fff8, 4'h7, 13'h1fff, 64'hffff_0000_aaaa_5555, 8'h3c, 1'b0);
        stop_test();
    end
endmodule

// ===== tb/pmw_pci_model.sv
// arbiter and fast-decoding 64-bit write target on the pci side
`timescale 1ns/1ps

module pmw_pci_model
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // bus wires as resolved by the bench
    input  wire logic       i_req_l,
    input  wire logic       i_frame_l,
    input  wire logic       i_irdy_l,
    input  wire logic [3:0] i_gnt_delay,
    // answers
    output logic            o_gnt_l,
    output logic            o_trdy_l,
    output logic            o_devsel_l,
    output logic            o_ack64_l
);
    logic [3:0] wait_cnt;
    logic       frame_q;

    // a nonzero delay models an arbiter busy with other masters
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_req_l)
        begin
            o_gnt_l  <= 1'b1;
            wait_cnt <= 4'h0;
        end
        else if (wait_cnt >= i_gnt_delay)
            o_gnt_l <= 1'b0;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end

    // released target lines return to their pull-up level
    always_ff @(posedge i_clk)
    begin
        frame_q <= i_frame_l;
        if (i_rst || (!i_irdy_l && !o_trdy_l))
            {o_devsel_l, o_ack64_l, o_trdy_l} <= 3'h7;
        else if (frame_q && !i_frame_l)
            {o_devsel_l, o_ack64_l, o_trdy_l} <= 3'h0;
    end
endmodule
